// ===== rtl/hsm_pkg.sv
// constants, field positions and types shared by both ends of the handshake spi link
// assumes a 50 mhz system clock on both ends
package hsm_pkg;
  // ==========================================================
  // timing
  localparam int CLK_NS = 20;
  localparam int BIT_RATE_KBPS = 1000;
  localparam int BIT_NS = 1000000 / BIT_RATE_KBPS;
  localparam int HALF_CYC = BIT_NS / 2 / CLK_NS;
  localparam int TIMEOUT_US = 16;
  localparam int TIMEOUT_CYC = TIMEOUT_US * 1000 / CLK_NS;
  localparam int SLOT_MS = 1;
  localparam int SLOT_CYC = SLOT_MS * 1000000 / CLK_NS;
  localparam logic [4:0] HALF_LAST = 5'(HALF_CYC - 1);
  localparam logic [9:0] TIMEOUT_LAST = 10'(TIMEOUT_CYC - 1);
  // ==========================================================
  // character and command format
  localparam logic [3:0] BITS_PER_CHAR = 4'h8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [7:0] CMD_STATUS = 8'h00;
  localparam logic [7:0] IDLE_FILL = 8'h00;
  localparam logic [1:0] MODE_RX = 2'h1;
  localparam logic [1:0] MODE_TX = 2'h2;
  localparam logic [1:0] MODE_TXRX = 2'h3;
  localparam int MODE_RX_BIT = 0;
  localparam int CMD_MASTER_TX_BIT = 7;
  localparam logic [1:0] REPLY_CAN_SEND = 2'h1;
  localparam logic [1:0] REPLY_CAN_ACCEPT = 2'h0;
  localparam logic [5:0] DEFAULT_CHARS = 6'h20;
  localparam logic [6:0] STATUS_LAST_IDX = 7'h1;
  // ==========================================================
  // register map, byte addresses
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RXSUM = 4'h8;
  localparam int CTRL_EN = 0;
  localparam int CTRL_MODE_LSB = 6;
  localparam int CTRL_CNT_LSB = 8;
  localparam int CTRL_SEED_LSB = 16;
  localparam logic [7:0] SEED_RST = 8'h20;
  localparam int STAT_BUSY = 0;
  localparam int STAT_TARGET = 1;
  localparam int STAT_TMO = 2;
  localparam int STAT_SKIP = 3;
  localparam int STAT_PHASE = 4;
  localparam int STAT_REPLY_LSB = 8;
  localparam int STAT_RX_LSB = 16;
  localparam int SUM_LSB = 0;
  localparam int SUM_CNT_LSB = 8;
  // ==========================================================
  // sequencer states
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_WAIT = 2'b01,
    S_SHIFT = 2'b11,
    S_END = 2'b10
  } hsm_state_t;
endpackage

// ===== rtl/hsm_link_if.sv
// link between the master and two slaves: selects, clock, data, shared handshake
// assumes one slave end with index 0 and one with index 1 are attached
`timescale 1ns/1ps
`default_nettype none
interface hsm_link_if;
  logic first_slave_select_n;
  logic second_slave_select_n;
  logic sck;
  logic mosi;
  wire logic [1:0] miso_drv;
  wire logic [1:0] miso_oe;
  wire logic [1:0] busy_drv;
  wire logic [1:0] busy_oe;
  logic miso;
  logic busy;
  // ==========================================================
  // shared lines, pulled high when nobody drives
  assign miso = miso_oe[0] ? miso_drv[0] : (miso_oe[1] ? miso_drv[1] : 1'b1);
  assign busy = busy_oe[0] ? busy_drv[0] : (busy_oe[1] ? busy_drv[1] : 1'b1);
  modport master (
    output first_slave_select_n,
    output second_slave_select_n,
    output sck,
    output mosi,
    input miso,
    input busy
  );
  modport slave (
    input first_slave_select_n,
    input second_slave_select_n,
    input sck,
    input mosi,
    output miso_drv,
    output miso_oe,
    output busy_drv,
    output busy_oe
  );
endinterface
`default_nettype wire

// ===== rtl/hsm_sync.sv
// two flip-flop synchroniser for pins from outside the clock domain
// assumes the clock enable of the end that instantiates it
`timescale 1ns/1ps
`default_nettype none
module hsm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;
  // ==========================================================
  // two stages
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      meta <= INIT;
      dout <= INIT;
    end else if (ce) begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/hsm_master.sv
// handshake spi master sequencer with avalon-mm control registers
// assumes hsm_link_if to two slaves and a 50 mhz clock
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - select first, then clock and shift data
// - no clocking before handshake seen low
// - slave drives handshake low when ready
// - one slot per 1 ms tick
// - 16 us handshake timeout from select
// - same wait after command byte
// - serial clock 1 mbps
// - 8-bit characters, msb first, single transfer
// - type 1 clock and data phase
// - done event after each character
// - up to 63 characters, default 32
// - every exchange opens with command byte
// - status command zero, reply counts
// - data commands: mode bits plus count
// - status slot, then data if enough
// - timeout or bad reply: release, switch
// - release select after status reply
// - alternate target slave after each cycle
// - both selects high after reset
// - always-ready slave ties handshake low
module hsm_master #(
  parameter int SLOT_CYCLES = hsm_pkg::SLOT_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  hsm_link_if.master link
);
  import hsm_pkg::*;
  localparam logic [31:0] SLOT_LAST = 32'(SLOT_CYCLES - 1);
  hsm_state_t state;
  logic miso_s, busy_s, en, slot_tick_event, handshake_timeout_tick, serial_done_event, data_slot, target;
  logic abort, reply_ok, last_tmo, last_skip, wr_take, start_shift;
  logic [1:0] mode, pin_s;
  logic [5:0] req_cnt;
  logic [7:0] seed, tx_sh, rx_sh, next_tx, last_reply, last_rx, rx_sum, done_cnt;
  logic [31:0] slot_cnt, rd_word;
  logic [9:0] wait_cnt;
  logic [4:0] div_cnt;
  logic [3:0] bit_cnt;
  logic [6:0] byte_idx, last_idx;
  // ==========================================================
  // pin synchronisers
  hsm_sync #(.W(2), .INIT(2'b11)) u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .ce(ce),
    .din({link.miso, link.busy}),
    .dout(pin_s)
  );
  assign miso_s = pin_s[1];
  assign busy_s = pin_s[0];
  // ==========================================================
  // avalon slave
  assign wr_take = ce && avs_write && !avs_waitrequest;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else if (ce) begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_word;
      end
    end
  end
  always_comb begin
    rd_word = '0;
    case (avs_address)
      REG_CTRL: begin
        rd_word[CTRL_EN] = en;
        rd_word[CTRL_MODE_LSB +: 2] = mode;
        rd_word[CTRL_CNT_LSB +: 6] = req_cnt;
        rd_word[CTRL_SEED_LSB +: 8] = seed;
      end
      REG_STATUS: begin
        rd_word[STAT_BUSY] = (state != S_IDLE);
        rd_word[STAT_TARGET] = target;
        rd_word[STAT_TMO] = last_tmo;
        rd_word[STAT_SKIP] = last_skip;
        rd_word[STAT_PHASE] = data_slot;
        rd_word[STAT_REPLY_LSB +: 8] = last_reply;
        rd_word[STAT_RX_LSB +: 8] = last_rx;
      end
      REG_RXSUM: begin
        rd_word[SUM_LSB +: 8] = rx_sum;
        rd_word[SUM_CNT_LSB +: 8] = done_cnt;
      end
      default: rd_word = '0;
    endcase
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      en <= 1'b0;
      mode <= MODE_TXRX;
      req_cnt <= DEFAULT_CHARS;
      seed <= SEED_RST;
    end else if (wr_take && avs_address == REG_CTRL) begin
      en <= avs_writedata[CTRL_EN];
      if (avs_writedata[CTRL_MODE_LSB +: 2] != CMD_STATUS[1:0]) begin
        mode <= avs_writedata[CTRL_MODE_LSB +: 2];
      end
      req_cnt <= avs_writedata[CTRL_CNT_LSB +: 6];
      seed <= avs_writedata[CTRL_SEED_LSB +: 8];
    end
  end
  // ==========================================================
  // slot timer
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      slot_cnt <= '0;
      slot_tick_event <= 1'b0;
    end else if (ce) begin
      slot_tick_event <= (slot_cnt == SLOT_LAST);
      slot_cnt <= (slot_cnt == SLOT_LAST) ? '0 : slot_cnt + 32'h1;
    end
  end
  // ==========================================================
  // byte to send and status reply check
  assign next_tx = data_slot ? ((byte_idx == '0) ? {mode, req_cnt} : seed + 8'(byte_idx - 7'h1)) : CMD_STATUS;
  assign last_idx = data_slot ? {1'b0, req_cnt} : STATUS_LAST_IDX;
  always_comb begin
    case (mode)
      MODE_RX: reply_ok = (rx_sh[7:6] == REPLY_CAN_SEND);
      MODE_TX: reply_ok = (rx_sh[7:6] == REPLY_CAN_ACCEPT);
      default: reply_ok = (rx_sh[7:6] == REPLY_CAN_SEND) || (rx_sh[7:6] == REPLY_CAN_ACCEPT);
    endcase
    reply_ok = reply_ok && (rx_sh[5:0] >= req_cnt);
  end
  // ==========================================================
  // bit engine: clock idles high, data out on fall, sampled on rise
  assign start_shift = (state == S_WAIT) && !busy_s;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      link.sck <= 1'b1;
      link.mosi <= 1'b0;
      div_cnt <= '0;
      bit_cnt <= '0;
      tx_sh <= '0;
      rx_sh <= '0;
      serial_done_event <= 1'b0;
    end else if (ce) begin
      serial_done_event <= 1'b0;
      if (start_shift) begin
        tx_sh <= next_tx;
        div_cnt <= '0;
        bit_cnt <= '0;
      end else if (state == S_SHIFT) begin
        if (div_cnt != HALF_LAST) begin
          div_cnt <= div_cnt + 5'h1;
        end else begin
          div_cnt <= '0;
          if (link.sck && bit_cnt == BITS_PER_CHAR) begin
            serial_done_event <= 1'b1;
          end else if (link.sck) begin
            link.sck <= 1'b0;
            link.mosi <= tx_sh[7];
          end else begin
            link.sck <= 1'b1;
            rx_sh <= {rx_sh[6:0], miso_s};
            tx_sh <= {tx_sh[6:0], 1'b0};
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
      end
    end
  end
  // ==========================================================
  // slot sequencer
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state <= S_IDLE;
      data_slot <= 1'b0;
      byte_idx <= '0;
      wait_cnt <= '0;
      target <= 1'b0;
      abort <= 1'b0;
      handshake_timeout_tick <= 1'b0;
      link.first_slave_select_n <= 1'b1;
      link.second_slave_select_n <= 1'b1;
    end else if (ce) begin
      handshake_timeout_tick <= 1'b0;
      case (state)
        S_IDLE: begin
          if (slot_tick_event && en) begin
            state <= S_WAIT;
            wait_cnt <= '0;
            byte_idx <= '0;
            abort <= 1'b0;
            link.first_slave_select_n <= target;
            link.second_slave_select_n <= !target;
          end
        end
        S_WAIT: begin
          if (!busy_s) begin
            state <= S_SHIFT;
          end else if (wait_cnt == TIMEOUT_LAST) begin
            handshake_timeout_tick <= 1'b1;
            abort <= 1'b1;
            state <= S_END;
          end else begin
            wait_cnt <= wait_cnt + 10'h1;
          end
        end
        S_SHIFT: begin
          if (serial_done_event) begin
            byte_idx <= byte_idx + 7'h1;
            wait_cnt <= '0;
            state <= (byte_idx == last_idx) ? S_END : S_WAIT;
          end
        end
        S_END: begin
          link.first_slave_select_n <= 1'b1;
          link.second_slave_select_n <= 1'b1;
          state <= S_IDLE;
          if (!data_slot && !abort && reply_ok) begin
            data_slot <= 1'b1;
          end else begin
            data_slot <= 1'b0;
            target <= !target;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
  // ==========================================================
  // status capture for software
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      last_tmo <= 1'b0;
      last_skip <= 1'b0;
      last_reply <= '0;
      last_rx <= '0;
      rx_sum <= '0;
      done_cnt <= '0;
    end else if (ce) begin
      if (handshake_timeout_tick) begin
        last_tmo <= 1'b1;
      end else if (state == S_END) begin
        last_tmo <= 1'b0;
      end
      if (state == S_END && !data_slot) begin
        last_skip <= abort || !reply_ok;
        if (!abort) begin
          last_reply <= rx_sh;
        end
      end
      if (serial_done_event && data_slot && byte_idx != '0 && mode[MODE_RX_BIT]) begin
        last_rx <= rx_sh;
        rx_sum <= rx_sum ^ rx_sh;
      end
      if (state == S_END && data_slot && !abort) begin
        done_cnt <= done_cnt + 8'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/hsm_slave.sv
// handshake spi slave end answering status and data commands
// assumes hsm_link_if from the master; IDX picks which select it answers
`timescale 1ns/1ps
`default_nettype none
module hsm_slave #(
  parameter int IDX = 0
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic slave_ready,
  input wire logic [7:0] status_reply,
  input wire logic [7:0] tx_seed,
  output logic [7:0] cmd_byte,
  output logic cmd_valid,
  output logic [7:0] rx_data,
  output logic rx_valid,
  hsm_link_if.slave link
);
  import hsm_pkg::*;

  logic my_sel_n;
  logic [2:0] pin_s;
  logic sel;
  logic sck_s;
  logic mosi_s;
  logic sck_q;
  logic sel_q;
  logic rise;
  logic fall;
  logic [7:0] tx_sh;
  logic [6:0] rx_sh;
  logic [7:0] byte_in;
  logic [2:0] bit_cnt;
  logic [6:0] byte_cnt;
  logic armed;
  logic busy_q;
  logic miso_q;

  // ==========================================================
  // pin synchronisers and edge detect
  assign my_sel_n = (IDX == 0) ? link.first_slave_select_n : link.second_slave_select_n;

  hsm_sync #(.W(3), .INIT(3'b110)) u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .ce(ce),
    .din({my_sel_n, link.sck, link.mosi}),
    .dout(pin_s)
  );
  assign sel = !pin_s[2];
  assign sck_s = pin_s[1];
  assign mosi_s = pin_s[0];
  assign rise = sck_s && !sck_q;
  assign fall = !sck_s && sck_q;
  assign byte_in = {rx_sh, mosi_s};

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sck_q <= 1'b1;
      sel_q <= 1'b0;
    end else if (ce) begin
      sck_q <= sck_s;
      sel_q <= sel;
    end
  end

  // ==========================================================
  // drive shared lines only while selected
  assign link.miso_drv[IDX] = miso_q;
  assign link.miso_oe[IDX] = sel_q;
  assign link.busy_drv[IDX] = busy_q;
  assign link.busy_oe[IDX] = sel_q;

  // ==========================================================
  // shifter, handshake and command decode
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tx_sh <= IDLE_FILL;
      rx_sh <= '0;
      bit_cnt <= '0;
      byte_cnt <= '0;
      armed <= 1'b1;
      busy_q <= 1'b1;
      miso_q <= 1'b0;
      cmd_byte <= '0;
      cmd_valid <= 1'b0;
      rx_data <= '0;
      rx_valid <= 1'b0;
    end else if (ce) begin
      cmd_valid <= 1'b0;
      rx_valid <= 1'b0;
      if (!sel) begin
        tx_sh <= IDLE_FILL;
        bit_cnt <= '0;
        byte_cnt <= '0;
        armed <= 1'b1;
        busy_q <= 1'b1;
        miso_q <= IDLE_FILL[7];
      end else begin
        if (armed && slave_ready) begin
          busy_q <= 1'b0;
        end
        if (fall) begin
          miso_q <= tx_sh[7];
        end
        if (rise) begin
          tx_sh <= {tx_sh[6:0], 1'b0};
          rx_sh <= {rx_sh[5:0], mosi_s};
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == LAST_BIT) begin
            busy_q <= 1'b1;
            armed <= 1'b0;
            byte_cnt <= byte_cnt + 7'h1;
            if (byte_cnt == '0) begin
              cmd_byte <= byte_in;
              cmd_valid <= 1'b1;
              tx_sh <= (byte_in == CMD_STATUS) ? status_reply : tx_seed;
            end else begin
              if (cmd_byte[CMD_MASTER_TX_BIT]) begin
                rx_data <= byte_in;
                rx_valid <= 1'b1;
              end
              tx_sh <= tx_seed + 8'(byte_cnt);
            end
          end
        end else if (!armed) begin
          armed <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/hsm_link_checker.sv
// link checker: selects, serial clock, data and handshake
// assumes resolved interface lines and the master's clock domain
`timescale 1ns/1ps
`default_nettype none
module hsm_link_checker #(
  parameter int SLOT_CYCLES = 50000
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic first_slave_select_n,
  input wire logic second_slave_select_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic busy
);
  import hsm_pkg::*;
  // ==========================================================
  // helper counters
  logic any_sel;
  logic prev_sel;
  logic prev_sck;
  logic last_tgt;
  logic [1:0] run;
  int low_cnt;
  int wait_cnt;
  int gap_cnt;
  int rises;
  assign any_sel = !first_slave_select_n || !second_slave_select_n;
  always_ff @(posedge clock) begin
    prev_sel <= rst_b && any_sel;
    prev_sck <= sck;
    low_cnt <= (!rst_b || sck) ? 0 : low_cnt + 1;
    wait_cnt <= (!rst_b || !any_sel || !sck || !busy) ? 0 : wait_cnt + 1;
    rises <= !any_sel ? 0 : rises + int'(sck && !prev_sck);
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      gap_cnt <= 0;
      run <= 2'h0;
      last_tgt <= 1'b0;
    end else if (any_sel && !prev_sel) begin
      gap_cnt <= 1;
      last_tgt <= first_slave_select_n;
      run <= (first_slave_select_n == last_tgt && run != 2'h0) ? run + 2'h1 : 2'h1;
    end else begin
      gap_cnt <= gap_cnt + 1;
    end
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  reset_idle_a: assert property (disable iff (1'b0)
    !rst_b |=> first_slave_select_n && second_slave_select_n && sck) else $error("link not idle after reset");
  one_select_a: assert property (first_slave_select_n || second_slave_select_n)
    else $error("both selects low");
  sck_idle_a: assert property (!any_sel |-> sck)
    else $error("serial clock low while deselected");
  half_low_a: assert property ($rose(sck) |-> low_cnt == HALF_CYC)
    else $error("serial clock low phase wrong");
  mosi_stable_a: assert property ($rose(sck) |-> $stable(mosi))
    else $error("data moved at sampling edge");
  miso_stable_a: assert property ($rose(sck) |-> $stable(miso))
    else $error("reply data moved at sampling edge");
  handshake_gate_a: assert property (wait_cnt >= 3 |-> !$fell(sck))
    else $error("clocking while handshake high");
  timeout_release_a: assert property (wait_cnt == 790 |-> ##[5:25] !any_sel)
    else $error("select not released after timeout");
  slot_period_a: assert property ((any_sel && !prev_sel && run != 2'h0) |-> gap_cnt % SLOT_CYCLES == 0)
    else $error("slot start off period");
  target_run_a: assert property (run != 2'h3)
    else $error("same slave selected three slots running");
  byte_whole_a: assert property ((prev_sel && !any_sel) |-> rises % 8 == 0)
    else $error("select released mid character");
  cover property (wait_cnt == 790);
  cover property (prev_sel && !any_sel && rises == 40);
  cover property (!second_slave_select_n && !prev_sel);
endmodule
`default_nettype wire

// ===== dv/handshake_spi_master_tb_top.sv
// bench: master and two slaves joined by the link interface
// assumes rtl design files and the link checker
`timescale 1ns/1ps
`default_nettype none
module handshake_spi_master_tb_top;
  import hsm_pkg::*;
  localparam int SLOT = 4000;
  localparam int LIMIT = 70000;
  logic clock;
  logic rst_b;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic ce;
  logic s0_ready;
  logic s1_ready;
  logic [7:0] s0_reply;
  logic [7:0] s0_seed;
  logic [7:0] cmd_byte0, cmd_byte1, rx_data0;
  logic cmd_valid0, cmd_valid1, rx_valid0;
  logic [7:0] cmd0[$];
  logic [7:0] cmd1[$];
  logic [7:0] rx0[$];
  logic [31:0] q;
  int mismatches;
  int checks;
  int cycles;
  // ==========================================================
  // design and checker
  hsm_link_if hsm_link_if_inst ();
  hsm_master #(.SLOT_CYCLES(SLOT)) hsm_master_inst (.clock(clock), .rst_b(rst_b), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(hsm_link_if_inst.master));
  hsm_slave #(.IDX(0)) hsm_slave_inst (.clock(clock), .rst_b(rst_b), .ce(ce), .slave_ready(s0_ready),
    .status_reply(s0_reply), .tx_seed(s0_seed), .cmd_byte(cmd_byte0), .cmd_valid(cmd_valid0),
    .rx_data(rx_data0), .rx_valid(rx_valid0), .link(hsm_link_if_inst.slave));
  hsm_slave #(.IDX(1)) hsm_slave_inst_b (.clock(clock), .rst_b(rst_b), .ce(ce), .slave_ready(s1_ready),
    .status_reply(8'h02), .tx_seed(8'h90), .cmd_byte(cmd_byte1), .cmd_valid(cmd_valid1),
    .rx_data(), .rx_valid(), .link(hsm_link_if_inst.slave));
  hsm_link_checker #(.SLOT_CYCLES(SLOT)) hsm_link_checker_inst (.clock(clock), .rst_b(rst_b),
    .first_slave_select_n(hsm_link_if_inst.first_slave_select_n),
    .second_slave_select_n(hsm_link_if_inst.second_slave_select_n), .sck(hsm_link_if_inst.sck),
    .mosi(hsm_link_if_inst.mosi), .miso(hsm_link_if_inst.miso), .busy(hsm_link_if_inst.busy));
  // ==========================================================
  // clock, monitors, timeout
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    if (cmd_valid0 === 1'b1)
      cmd0.push_back(cmd_byte0);
    if (cmd_valid1 === 1'b1)
      cmd1.push_back(cmd_byte1);
    if (rx_valid0 === 1'b1)
      rx0.push_back(rx_data0);
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      $display("ERROR at %0t: cycles %h limit %h", $time, cycles, LIMIT);
      results();
    end
  end
  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
      @(posedge clock);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic phase(input logic [1:0] m, input logic [7:0] ms, input logic [7:0] ss, input logic [7:0] r0,
                       input logic s1r);
    cmd0.delete();
    cmd1.delete();
    rx0.delete();
    s0_seed <= ss;
    s0_reply <= r0;
    s1_ready <= s1r;
    bus(1'b1, REG_CTRL, {8'h00, ms, 2'b00, 6'h04, m, 5'h00, 1'b1});
    @(negedge hsm_link_if_inst.second_slave_select_n);
    @(posedge hsm_link_if_inst.second_slave_select_n);
    bus(1'b1, REG_CTRL, {8'h00, ms, 2'b00, 6'h04, m, 5'h00, 1'b0});
  endtask
  task automatic chk_slot(input logic [7:0] c, input logic [7:0] seed, input logic [31:0] nrx);
    chk(32'(cmd0.size()), 32'h2);
    chk({24'h0, cmd0[0]}, {24'h0, CMD_STATUS});
    chk({24'h0, cmd0[1]}, {24'h0, c});
    chk(32'(rx0.size()), nrx);
    foreach (rx0[k])
      chk({24'h0, rx0[k]}, {24'h0, seed + 8'(k)});
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    rst_b = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    ce = 1'b1;
    s0_ready = 1'b1;
    s1_ready = 1'b1;
    s0_reply = 8'h3f;
    s0_seed = 8'h00;
    mismatches = 0;
    checks = 0;
    cycles = 0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    chk({30'h0, hsm_link_if_inst.first_slave_select_n, hsm_link_if_inst.second_slave_select_n}, 32'h3);
    fork
      bus(1'b0, REG_CTRL, 32'h0);
      begin
        ce <= 1'b0;
        repeat (3) @(posedge clock);
        chk({31'h0, avs_waitrequest}, 32'h1);
        ce <= 1'b1;
      end
    join
    chk(q, 32'h002020c0);
    bus(1'b0, 4'hc, 32'h0);
    chk(q, 32'h0);
    $display("test reset done");
    phase(MODE_TXRX, 8'h41, 8'h35, 8'h3f, 1'b1);
    chk_slot(8'hc4, 8'h41, 32'h4);
    chk(32'(cmd1.size()), 32'h1);
    bus(1'b0, REG_STATUS, 32'h0);
    chk({8'h0, q[23:8], 3'h0, q[4:0]}, 32'h00380208);
    bus(1'b0, REG_RXSUM, 32'h0);
    chk({16'h0, q[15:0]}, 32'h0000010c);
    $display("test full duplex done");
    phase(MODE_RX, 8'h41, 8'h50, 8'h7f, 1'b0);
    chk_slot(8'h44, 8'h00, 32'h0);
    chk(32'(cmd1.size()), 32'h0);
    bus(1'b0, REG_STATUS, 32'h0);
    chk({8'h0, q[23:16], 11'h0, q[4:0]}, 32'h0053000c);
    bus(1'b0, REG_RXSUM, 32'h0);
    chk({24'h0, q[15:8]}, 32'h2);
    $display("test receive and timeout done");
    phase(MODE_TX, 8'h61, 8'h70, 8'h3f, 1'b0);
    chk_slot(8'h84, 8'h61, 32'h4);
    bus(1'b0, REG_STATUS, 32'h0);
    chk({8'h0, q[23:16], 11'h0, q[4:0]}, 32'h0053000c);
    bus(1'b0, REG_RXSUM, 32'h0);
    chk({24'h0, q[15:8]}, 32'h3);
    $display("test transmit done");
    results();
  end
endmodule
`default_nettype wire
